// file: source_aux_status_video_timing_regs.sv
// register bank holding aux channel status, hot plug pulse length and
// the main stream video timing attributes, reached over apb.
// assumes aux controller signals are on clk; the hot plug pin is async.
`timescale 1ns/1ps

module source_aux_status_video_timing_regs
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // aux controller status
  input wire aux_timing_pkg::aux_events_s aux_in,
  // hot plug detect pin, asynchronous
  input wire logic hot_plug_pin,
  // video timing toward framing logic
  output aux_timing_pkg::video_timing_s timing_out,
  // interrupt
  output logic irq
);

  // whole state of the bank
  typedef struct packed {
    logic [2:0] hpd_sync;       // three-stage pin synchroniser
    logic hpd_level;            // filtered pin level
    logic [4:0] us_div;         // cycles within current microsecond
    logic [15:0] low_us;        // running low time in microseconds
    logic [15:0] pulse_len;     // last completed pulse length
    logic [7:0] reply_state;    // copy of reply state code
    logic reply_error;          // sticky reply error flag
    logic request_active;       // request controller busy
    logic reply_active;         // reply receiver busy
    logic reply_received;       // valid reply since last request
    logic [15:0] line_total;    // clocks per line
    logic [15:0] frame_total;   // lines per frame
    logic [1:0] polarity;       // vsync and hsync polarity
    logic [14:0] hs_width;      // hsync width in clocks
    logic [14:0] vs_width;      // vsync width in lines
    logic [6:0] int_status;     // sticky event bits
    logic [6:0] int_mask;       // one masks the event
    logic [6:0] rd_clear;       // status bits captured for clear
    logic [31:0] prdata;        // apb read data
    logic pready;               // apb ready
    logic pslverr;              // apb error
    logic irq;                  // interrupt line
  } bank_s;

  bank_s r_reg;   // registered state
  bank_s r_next;  // next state

  // next-state logic for every field
  always_comb
  begin
    // scratch values, all given a value just below
    logic setup;
    logic done;
    logic hit;
    logic [31:0] rd;
    logic [6:0] set_bits;
    logic [11:0] addr;
    logic pulse_event;
    setup = 1'b0;
    done = 1'b0;
    hit = 1'b0;
    rd = 32'h0000_0000;
    set_bits = 7'h00;
    addr = paddr;
    pulse_event = 1'b0;
    r_next = r_reg;

    // pin synchroniser, first stage only feeds the second
    r_next.hpd_sync = {r_reg.hpd_sync[1:0], hot_plug_pin};

    // level counts once stages two and three agree
    if (r_reg.hpd_sync[1] == r_reg.hpd_sync[2])
    begin
      r_next.hpd_level = r_reg.hpd_sync[2];
    end

    // measure low pulse width in microseconds
    if (r_reg.hpd_level == 1'b0)
    begin
      // low: run the microsecond prescaler
      if (r_reg.us_div == aux_timing_pkg::US_DIV_LAST)
      begin
        r_next.us_div = 5'h00;
        // saturate rather than wrap on long pulses
        if (r_reg.low_us != aux_timing_pkg::PULSE_LEN_MAX)
        begin
          r_next.low_us = r_reg.low_us + 16'h0001;
        end
      end
      else
      begin
        r_next.us_div = r_reg.us_div + 5'h01;
      end
      // end of pulse: line returns high
      if ((r_reg.hpd_sync[1] == r_reg.hpd_sync[2]) && r_reg.hpd_sync[2])
      begin
        // the last whole microsecond may complete in this very cycle
        r_next.pulse_len = r_next.low_us;
        pulse_event = 1'b1;
        r_next.us_div = 5'h00;
        r_next.low_us = 16'h0000;
      end
    end
    else
    begin
      // high: hold the counters cleared
      r_next.us_div = 5'h00;
      r_next.low_us = 16'h0000;
    end

    // reply status observation
    r_next.reply_state = aux_in.reply_state;
    r_next.request_active = aux_in.request_busy;
    r_next.reply_active = aux_in.reply_busy;

    // new request clears the per-transaction flags
    if (aux_in.request_start)
    begin
      r_next.reply_received = 1'b0;
      r_next.reply_error = 1'b0;
    end
    // a set in the same cycle wins over the clear
    if (aux_in.reply_error)
    begin
      r_next.reply_error = 1'b1;
    end
    if (aux_in.reply_valid)
    begin
      r_next.reply_received = 1'b1;
    end

    // collect events into interrupt set bits
    set_bits[aux_timing_pkg::INT_HOT_PLUG_PULSE_BIT] = pulse_event;
    // reply events feed the same sticky status
    set_bits[aux_timing_pkg::INT_REPLY_RECEIVED_BIT] = aux_in.reply_valid;
    set_bits[aux_timing_pkg::INT_REPLY_ERROR_BIT] = aux_in.reply_error;

    // apb phases
    setup = psel && !penable;
    // access phase completes only while our ready is up
    done = psel && penable && r_reg.pready;

    // read mux and address decode
    unique case (addr)
      aux_timing_pkg::INT_STATUS_ADDR:
      begin
        hit = 1'b1;
        // sticky event bits
        rd[6:0] = r_reg.int_status;
      end
      aux_timing_pkg::INT_MASK_ADDR:
      begin
        hit = 1'b1;
        // one bit per masked event
        rd[6:0] = r_reg.int_mask;
      end
      aux_timing_pkg::REPLY_FLAGS_ADDR:
      begin
        // bits above eleven stay zero
        hit = 1'b1;
        // state code sits above the four flags
        rd[aux_timing_pkg::REPLY_STATE_MSB:aux_timing_pkg::REPLY_STATE_LSB] =
          r_reg.reply_state;
        rd[aux_timing_pkg::REPLY_ERROR_BIT] = r_reg.reply_error;
        rd[aux_timing_pkg::REQUEST_ACTIVE_BIT] = r_reg.request_active;
        rd[aux_timing_pkg::REPLY_ACTIVE_BIT] = r_reg.reply_active;
        rd[aux_timing_pkg::REPLY_RECEIVED_BIT] = r_reg.reply_received;
      end
      aux_timing_pkg::PULSE_LEN_ADDR:
      begin
        hit = 1'b1;
        // last measured low time in microseconds
        rd[15:0] = r_reg.pulse_len;
      end
      aux_timing_pkg::LINE_TOTAL_ADDR:
      begin
        hit = 1'b1;
        // clocks per line
        rd[15:0] = r_reg.line_total;
      end
      aux_timing_pkg::FRAME_TOTAL_ADDR:
      begin
        hit = 1'b1;
        // lines per frame
        rd[15:0] = r_reg.frame_total;
      end
      aux_timing_pkg::POLARITY_ADDR:
      begin
        hit = 1'b1;
        // vsync bit above hsync bit
        rd[1:0] = r_reg.polarity;
      end
      aux_timing_pkg::HS_WIDTH_ADDR:
      begin
        hit = 1'b1;
        // fifteen-bit width, top bit reads zero
        rd[14:0] = r_reg.hs_width;
      end
      aux_timing_pkg::VS_WIDTH_ADDR:
      begin
        hit = 1'b1;
        // width in lines, top bit reads zero
        rd[14:0] = r_reg.vs_width;
      end
      default:
      begin
        // unmapped: error response, zero data
        hit = 1'b0;
      end
    endcase

    // ready drops after each completed access
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;

    // setup cycle: prepare answer for the access phase
    if (setup)
    begin
      r_next.pready = 1'b1;
      // unmapped or misaligned address is refused
      r_next.pslverr = !hit;
      // writes and refused reads return zero data
      r_next.prdata = (hit && !pwrite) ? rd : 32'h0000_0000;
      // remember which status bits this read returns
      if (!pwrite && (addr == aux_timing_pkg::INT_STATUS_ADDR))
      begin
        r_next.rd_clear = r_reg.int_status;
      end
      else
      begin
        r_next.rd_clear = 7'h00;
      end
    end

    // completion edge: read clears only the returned bits
    if (done && !pwrite)
    begin
      r_next.int_status = r_reg.int_status & ~r_reg.rd_clear;
    end

    // completion edge: writes take effect, read-only targets ignore them
    if (done && pwrite && !r_reg.pslverr)
    begin
      unique case (addr)
        aux_timing_pkg::INT_MASK_ADDR:
        begin
          // one masks the matching event
          r_next.int_mask = pwdata[6:0];
        end
        aux_timing_pkg::LINE_TOTAL_ADDR:
        begin
          // upper half of the word is dropped
          r_next.line_total = pwdata[15:0];
        end
        aux_timing_pkg::FRAME_TOTAL_ADDR:
        begin
          // upper half of the word is dropped
          r_next.frame_total = pwdata[15:0];
        end
        aux_timing_pkg::POLARITY_ADDR:
        begin
          // only the two polarity bits are kept
          r_next.polarity = pwdata[1:0];
        end
        aux_timing_pkg::HS_WIDTH_ADDR:
        begin
          // bit fifteen and above are dropped
          r_next.hs_width = pwdata[14:0];
        end
        aux_timing_pkg::VS_WIDTH_ADDR:
        begin
          // bit fifteen and above are dropped
          r_next.vs_width = pwdata[14:0];
        end
        default:
        begin
          // status, reply flags and pulse length keep their value
          r_next.int_mask = r_next.int_mask;
        end
      endcase
    end

    // new events set status bits, set wins over read clear
    r_next.int_status = r_next.int_status | set_bits;

    // interrupt high while any unmasked status bit is set
    r_next.irq = |(r_next.int_status & ~r_next.int_mask);
  end

  // state register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // pin idles high: start high so no false pulse follows reset
      r_reg.hpd_sync <= 3'h7;
      r_reg.hpd_level <= 1'b1;
      r_reg.us_div <= 5'h00;
      r_reg.low_us <= 16'h0000;
      r_reg.pulse_len <= 16'h0000;
      // aux observation starts idle
      r_reg.reply_state <= 8'h00;
      r_reg.reply_error <= 1'b0;
      r_reg.request_active <= 1'b0;
      r_reg.reply_active <= 1'b0;
      r_reg.reply_received <= 1'b0;
      // video timing attributes
      r_reg.line_total <= aux_timing_pkg::TIMING16_RESET;
      r_reg.frame_total <= aux_timing_pkg::TIMING16_RESET;
      r_reg.polarity <= aux_timing_pkg::POLARITY_RESET;
      r_reg.hs_width <= aux_timing_pkg::TIMING15_RESET;
      r_reg.vs_width <= aux_timing_pkg::TIMING15_RESET;
      // no events pending, all masked
      r_reg.int_status <= 7'h00;
      r_reg.int_mask <= aux_timing_pkg::INT_MASK_RESET;
      r_reg.rd_clear <= 7'h00;
      // bus answer and interrupt quiet
      r_reg.prdata <= 32'h0000_0000;
      r_reg.pready <= 1'b0;
      r_reg.pslverr <= 1'b0;
      r_reg.irq <= 1'b0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // bus outputs straight from the state register
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  // level interrupt, registered with the status bits
  assign irq = r_reg.irq;

  // timing attributes straight from the state register
  assign timing_out.line_total_clocks = r_reg.line_total;
  assign timing_out.frame_total_lines = r_reg.frame_total;
  // one selects an active high pulse
  assign timing_out.vsync_active_high =
    r_reg.polarity[aux_timing_pkg::VSYNC_POL_BIT];
  assign timing_out.hsync_active_high =
    r_reg.polarity[aux_timing_pkg::HSYNC_POL_BIT];
  // sync widths in clocks and in lines
  assign timing_out.horiz_sync_pulse_width = r_reg.hs_width;
  assign timing_out.vert_sync_pulse_width = r_reg.vs_width;

endmodule : source_aux_status_video_timing_regs

// file: aux_timing_pkg.sv
// constants, field positions and carrier structs for the aux status and
// video timing register bank.
// assumes a 20 mhz register clock and a 12-bit apb byte address.
package aux_timing_pkg;

  // register byte addresses
  localparam logic [11:0] INT_STATUS_ADDR = 12'h140;
  localparam logic [11:0] INT_MASK_ADDR = 12'h144;
  localparam logic [11:0] REPLY_FLAGS_ADDR = 12'h14c;
  localparam logic [11:0] PULSE_LEN_ADDR = 12'h150;
  localparam logic [11:0] LINE_TOTAL_ADDR = 12'h180;
  localparam logic [11:0] FRAME_TOTAL_ADDR = 12'h184;
  localparam logic [11:0] POLARITY_ADDR = 12'h188;
  localparam logic [11:0] HS_WIDTH_ADDR = 12'h18c;
  localparam logic [11:0] VS_WIDTH_ADDR = 12'h190;

  // reply status field positions
  localparam int REPLY_STATE_LSB = 4;
  localparam int REPLY_STATE_MSB = 11;
  localparam int REPLY_ERROR_BIT = 3;
  localparam int REQUEST_ACTIVE_BIT = 2;
  localparam int REPLY_ACTIVE_BIT = 1;
  localparam int REPLY_RECEIVED_BIT = 0;

  // polarity field positions
  localparam int VSYNC_POL_BIT = 1;
  localparam int HSYNC_POL_BIT = 0;

  // interrupt status and mask layout
  localparam int INT_WIDTH = 7;
  localparam int INT_REPLY_RECEIVED_BIT = 2;
  localparam int INT_HOT_PLUG_PULSE_BIT = 4;
  localparam int INT_REPLY_ERROR_BIT = 6;

  // reset values
  localparam logic [6:0] INT_MASK_RESET = 7'h7f;
  localparam logic [15:0] TIMING16_RESET = 16'h0000;
  localparam logic [14:0] TIMING15_RESET = 15'h0000;
  localparam logic [1:0] POLARITY_RESET = 2'h0;

  // timing: microsecond prescaler derived from the clock period
  localparam int CLK_PERIOD_NS = 50;
  localparam int MICROSECOND_NS = 1000;
  localparam int CYCLES_PER_US = MICROSECOND_NS / CLK_PERIOD_NS;
  localparam logic [4:0] US_DIV_LAST = 5'(CYCLES_PER_US - 1);
  localparam logic [15:0] PULSE_LEN_MAX = 16'hffff;

  // events and levels from the aux request and reply controllers
  typedef struct packed {
    logic request_start;  // one-cycle pulse: first bit goes out
    logic request_busy;   // level: request being driven
    logic reply_busy;     // level: reply being received
    logic reply_valid;    // one-cycle pulse: complete valid reply
    logic reply_error;    // one-cycle pulse: reply fault seen
    logic [7:0] reply_state;  // reply state machine code
  } aux_events_s;

  // video timing attributes toward the framing logic
  typedef struct packed {
    logic [15:0] line_total_clocks;
    logic [15:0] frame_total_lines;
    logic vsync_active_high;
    logic hsync_active_high;
    logic [14:0] horiz_sync_pulse_width;
    logic [14:0] vert_sync_pulse_width;
  } video_timing_s;

endpackage : aux_timing_pkg

// file: aux_regs_monitor.sv
// checker for the aux status and video timing register bank
// assumes it is bound to the bank's top module and sees its ports only
`timescale 1ns/1ps
module aux_regs_monitor
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // timing toward framing logic
  input wire aux_timing_pkg::video_timing_s timing_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // setup phase of a transfer
  sequence setup_s;
    psel && !penable;
  endsequence
  // completed write to one address
  sequence wr_done_s(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  // zero wait states: answer one cycle wide, right after setup
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  setup_ready_a: assert property (setup_s |=> pready)
    else $error("no pready after setup");
  idle_ready_a: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  misalign_err_a: assert property (setup_s ##0 paddr[1:0] != 2'b00 |=> pslverr && prdata == 0)
    else $error("misaligned access not refused");
  reserved_zero_a: assert property (setup_s ##0 (!pwrite &&
    paddr == aux_timing_pkg::REPLY_FLAGS_ADDR) |=> prdata[31:12] == 20'h0_0000)
    else $error("reply flags reserved bits not zero");
  line_total_a: assert property (wr_done_s(aux_timing_pkg::LINE_TOTAL_ADDR) |=>
    timing_out.line_total_clocks == $past(pwdata[15:0]))
    else $error("line total not applied");
  polarity_a: assert property (wr_done_s(aux_timing_pkg::POLARITY_ADDR) |=>
    {timing_out.vsync_active_high, timing_out.hsync_active_high} == $past(pwdata[1:0]))
    else $error("polarity not applied");
  hs_width_a: assert property (wr_done_s(aux_timing_pkg::HS_WIDTH_ADDR) |=>
    timing_out.horiz_sync_pulse_width == $past(pwdata[14:0]))
    else $error("hsync width not applied");
endmodule : aux_regs_monitor

bind source_aux_status_video_timing_regs aux_regs_monitor u_mon (.clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timing_out);

// file: source_aux_status_video_timing_regs_tb.sv
// self-checking bench for the aux status and video timing register bank
// assumes apb answers come before the watchdog span and a 20 mhz clock
`timescale 1ns/1ps
module source_aux_status_video_timing_regs_tb;
  // bench stimulus and design outputs
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  aux_timing_pkg::aux_events_s aux_in = '0;
  logic hot_plug_pin = 1'b1;
  aux_timing_pkg::video_timing_s timing_out;
  logic irq;
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic er;
  // timing registers, write values and expected readback
  localparam logic [11:0] TA [5] = '{aux_timing_pkg::LINE_TOTAL_ADDR,
    aux_timing_pkg::FRAME_TOTAL_ADDR, aux_timing_pkg::POLARITY_ADDR,
    aux_timing_pkg::HS_WIDTH_ADDR, aux_timing_pkg::VS_WIDTH_ADDR};
  localparam logic [31:0] TW [5] = '{32'hffff_ffff, 32'h1234_5678, 32'hffff_fffe,
    32'hffff_ffff, 32'h0000_8001};
  localparam logic [31:0] TR [5] = '{32'h0000_ffff, 32'h0000_5678, 32'h0000_0002,
    32'h0000_7fff, 32'h0000_0001};
  localparam logic [11:0] FLAGS = aux_timing_pkg::REPLY_FLAGS_ADDR;
  localparam logic [11:0] STAT = aux_timing_pkg::INT_STATUS_ADDR;

  // 50 ns clock
  always #25 clk = ~clk;

  source_aux_status_video_timing_regs u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .aux_in, .hot_plug_pin, .timing_out, .irq);

  // compare one value, count it, report a mismatch
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // wait ends at pready; only the watchdog ends a wait that never sees it
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read and compare
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    check(what, 64'(rd), 64'(exp));
  endtask : rchk

  // one-cycle aux event pulses, then let flags settle
  task automatic pulse(input logic st, input logic ok, input logic bad);
    @(posedge clk);
    aux_in.request_start <= st;
    aux_in.reply_valid <= ok;
    aux_in.reply_error <= bad;
    @(posedge clk);
    aux_in.request_start <= 1'b0;
    aux_in.reply_valid <= 1'b0;
    aux_in.reply_error <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    rchk(STAT, 32'h0000_0000, "status reset");
    rchk(aux_timing_pkg::INT_MASK_ADDR, 32'h0000_007f, "mask reset");
    rchk(FLAGS, 32'h0000_0000, "flags reset");
    for (int i = 0; i < 5; i++)
      rchk(TA[i], 32'h0000_0000, "timing reset");
    $display("test reset done");
    // widths and reserved bits of the timing registers
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, TA[i], TW[i]);
      rchk(TA[i], TR[i], "timing readback");
    end
    check("timing out", timing_out, {16'hffff, 16'h5678, 1'b1, 1'b0, 15'h7fff, 15'h0001});
    $display("test timing done");
    // aux levels and events
    aux_in.reply_state <= 8'ha5;
    aux_in.request_busy <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(FLAGS, 32'h0000_0a54, "request active");
    aux_in.request_busy <= 1'b0;
    aux_in.reply_busy <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(FLAGS, 32'h0000_0a52, "reply active");
    pulse(1'b0, 1'b1, 1'b1);
    rchk(FLAGS, 32'h0000_0a5b, "reply done");
    apb(1'b1, FLAGS, 32'hffff_ffff);
    rchk(FLAGS, 32'h0000_0a5b, "flags write");
    pulse(1'b1, 1'b0, 1'b0);
    rchk(FLAGS, 32'h0000_0a52, "request start");
    rchk(STAT, 32'h0000_0044, "reply events");
    rchk(STAT, 32'h0000_0000, "status cleared");
    $display("test aux done");
    // interrupt raise, mask and clear
    apb(1'b1, aux_timing_pkg::INT_MASK_ADDR, 32'h0000_007b);
    pulse(1'b0, 1'b1, 1'b1);
    check("irq raised", 64'(irq), 64'h1);
    rchk(STAT, 32'h0000_0044, "status irq");
    @(posedge clk);
    check("irq cleared", 64'(irq), 64'h0);
    $display("test irq done");
    // hot plug pulse of ten microseconds
    apb(1'b1, aux_timing_pkg::INT_MASK_ADDR, 32'h0000_006f);
    hot_plug_pin <= 1'b0;
    repeat (10 * aux_timing_pkg::CYCLES_PER_US) @(posedge clk);
    hot_plug_pin <= 1'b1;
    repeat (10) @(posedge clk);
    check("irq hot plug", 64'(irq), 64'h1);
    rchk(STAT, 32'h0000_0010, "pulse event");
    rchk(aux_timing_pkg::PULSE_LEN_ADDR, 32'h0000_000a, "pulse length");
    apb(1'b1, aux_timing_pkg::PULSE_LEN_ADDR, 32'h0000_1234);
    rchk(aux_timing_pkg::PULSE_LEN_ADDR, 32'h0000_000a, "length write");
    $display("test hot plug done");
    // refused accesses
    apb(1'b0, 12'h17c, 32'h0000_0000);
    check("unmapped err", {er, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, 12'h181, 32'h0000_0000);
    check("misaligned err", 64'(er), 64'h1);
    $display("test refusal done");
    finish_test();
  end

  // watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule : source_aux_status_video_timing_regs_tb
